// File: inc/srgs_pkg.sv
package srgs_pkg;
  // clock rate
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // absolute floors on the blanking windows
  localparam int unsigned TON_FLOOR_NS  = 55;
  localparam int unsigned TOFF_FLOOR_NS = 245;
  // least times round up
  localparam int unsigned TON_FLOOR_CYC  = (TON_FLOOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TOFF_FLOOR_CYC = (TOFF_FLOOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // default configured windows
  localparam int unsigned TON_DEF_CYC  = 10;
  localparam int unsigned TOFF_DEF_CYC = 20;
  localparam int unsigned CNT_W        = 16;

  // synchronised comparator decisions
  typedef struct packed {
    logic below_on;
    logic above_off;
    logic above_rearm;
  } srgs_cmp_t;

  typedef enum logic [1:0] {
    SRGS_SYNC = 2'b00,
    SRGS_ARM  = 2'b01,
    SRGS_ON   = 2'b11,
    SRGS_OFF  = 2'b10
  } srgs_state_t;
endpackage

// File: logic/srgs_seq.sv
`timescale 1ns/1ns
module srgs_seq #(
  parameter int unsigned CNT_W = srgs_pkg::CNT_W
) (
  // clock and reset
  input  wire logic             I_CLK,
  input  wire logic             I_RESETN,
  // comparator decisions
  input  wire logic             I_TURN_ON_THRESHOLD,
  input  wire logic             I_TURN_OFF_THRESHOLD,
  input  wire logic             I_REARM_THRESHOLD,
  // light-load disable, high while disabled
  input  wire logic             I_LIGHT_LOAD_INPUT,
  // configured windows in clock cycles
  input  wire logic [CNT_W-1:0] I_TON_CYC,
  input  wire logic [CNT_W-1:0] I_TOFF_CYC,
  // gate drive
  output logic                  O_GATE_DRIVE_OUTPUT
);
  localparam logic [CNT_W-1:0] TON_MIN  = CNT_W'(srgs_pkg::TON_FLOOR_CYC);
  localparam logic [CNT_W-1:0] TOFF_MIN = CNT_W'(srgs_pkg::TOFF_FLOOR_CYC);
  localparam logic [CNT_W-1:0] ONE      = CNT_W'(1);

  srgs_pkg::srgs_cmp_t meta_reg, sync_reg, meta_next, sync_next;
  logic                lld_meta_reg, lld_sync_reg;
  srgs_pkg::srgs_state_t state_reg, state_next;
  logic [CNT_W-1:0]    cnt_reg, cnt_next;
  logic                drv_reg, drv_next;
  logic [CNT_W-1:0]    ton_lim, toff_lim;

  function automatic logic [CNT_W-1:0] clamp_floor(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] f);
    clamp_floor = (v < f) ? f : v;
  endfunction

  always_comb begin
    meta_next = '{below_on: I_TURN_ON_THRESHOLD, above_off: I_TURN_OFF_THRESHOLD,
                  above_rearm: I_REARM_THRESHOLD};
    sync_next = meta_reg;
    ton_lim   = clamp_floor(I_TON_CYC, TON_MIN);
    toff_lim  = clamp_floor(I_TOFF_CYC, TOFF_MIN);
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      meta_reg     <= '0;
      sync_reg     <= '0;
      lld_meta_reg <= 1'b1;
      lld_sync_reg <= 1'b1;
    end else begin
      meta_reg     <= meta_next;
      sync_reg     <= sync_next;
      lld_meta_reg <= I_LIGHT_LOAD_INPUT;
      lld_sync_reg <= lld_meta_reg;
    end
  end

  // off-time counting shared by start-up sync and post turn-off
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    drv_next   = 1'b0;
    if (lld_sync_reg) begin
      // disabled: hold in sync so leaving it is a wake-up
      state_next = srgs_pkg::SRGS_SYNC;
      cnt_next   = '0;
    end else begin
      case (state_reg)
        srgs_pkg::SRGS_SYNC, srgs_pkg::SRGS_OFF: begin
          if (!sync_reg.above_rearm) begin
            cnt_next = '0;
          end else if (cnt_reg + ONE >= toff_lim) begin
            state_next = srgs_pkg::SRGS_ARM;
            cnt_next   = '0;
          end else begin
            cnt_next = cnt_reg + ONE;
          end
        end
        srgs_pkg::SRGS_ARM: begin
          if (sync_reg.below_on) begin
            state_next = srgs_pkg::SRGS_ON;
            drv_next   = 1'b1;
            cnt_next   = '0;
          end
        end
        srgs_pkg::SRGS_ON: begin
          drv_next = 1'b1;
          if (cnt_reg + ONE < ton_lim) begin
            cnt_next = cnt_reg + ONE;
          end else if (sync_reg.above_off) begin
            state_next = srgs_pkg::SRGS_OFF;
            drv_next   = 1'b0;
            cnt_next   = '0;
          end
        end
        default: begin
          state_next = srgs_pkg::SRGS_SYNC;
          cnt_next   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_reg <= srgs_pkg::SRGS_SYNC;
      cnt_reg   <= '0;
      drv_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      drv_reg   <= drv_next;
    end
  end

  assign O_GATE_DRIVE_OUTPUT = drv_reg;

  // helper: cycles drive has been high
  logic [CNT_W-1:0] hi_cnt;
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      hi_cnt <= '0;
    end else begin
      hi_cnt <= drv_reg ? hi_cnt + ONE : '0;
    end
  end

  sequence drive_rise_s;
    !drv_reg ##1 drv_reg;
  endsequence

  // waiting in sync or off with the block enabled
  sequence off_window_s;
    (state_reg == srgs_pkg::SRGS_SYNC || state_reg == srgs_pkg::SRGS_OFF) && !lld_sync_reg;
  endsequence

  // the step out of the off window into arming
  sequence arm_entry_s;
    off_window_s ##1 state_reg == srgs_pkg::SRGS_ARM;
  endsequence

  on_needs_arm_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    $rose(drv_reg) |-> $past(state_reg) == srgs_pkg::SRGS_ARM && $past(sync_reg.below_on))
    else $error("drive rose without arming and turn-on decision");
  on_blank_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    $fell(drv_reg) |-> $past(hi_cnt) + ONE >= ton_lim)
    else $error("drive dropped inside on window");
  off_prompt_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN || lld_sync_reg)
    state_reg == srgs_pkg::SRGS_ON && cnt_reg + ONE >= ton_lim && sync_reg.above_off |=> !drv_reg)
    else $error("drive not dropped after turn-off decision");
  toff_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (state_reg == srgs_pkg::SRGS_OFF || state_reg == srgs_pkg::SRGS_SYNC) && !sync_reg.above_rearm
    |=> cnt_reg == '0)
    else $error("off timer not cleared");
  toff_count_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN || lld_sync_reg)
    state_reg == srgs_pkg::SRGS_OFF && sync_reg.above_rearm && cnt_reg + ONE < toff_lim
    |=> cnt_reg == $past(cnt_reg) + ONE)
    else $error("off timer not running");
  // an arm entry must close a full clean off window, whichever edge it came on
  arm_after_full_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    arm_entry_s |-> $past(cnt_reg) + ONE >= toff_lim && $past(sync_reg.above_rearm))
    else $error("arming before off window expired");
  wake_sync_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    lld_sync_reg |=> state_reg == srgs_pkg::SRGS_SYNC && !drv_reg)
    else $error("disable not forcing sync wait");
  floor_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    ton_lim >= TON_MIN && toff_lim >= TOFF_MIN)
    else $error("window below floor");

  // every pulse leaves from the armed state only
  pulse_from_arm_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    drive_rise_s |-> $past(state_reg) == srgs_pkg::SRGS_ARM)
    else $error("pulse not started from arm");

  // drive is registered with the state, so the two never part
  drive_in_on_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    drv_reg |-> state_reg == srgs_pkg::SRGS_ON)
    else $error("drive high outside on state");

  on_window_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN || lld_sync_reg)
    state_reg == srgs_pkg::SRGS_ON && cnt_reg + ONE < ton_lim |=> state_reg == srgs_pkg::SRGS_ON && drv_reg)
    else $error("on window cut short");

  off_entry_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    $fell(drv_reg) |-> state_reg == srgs_pkg::SRGS_OFF || state_reg == srgs_pkg::SRGS_SYNC)
    else $error("drive fell without entering off");

  // off timer always starts from zero at turn-off
  off_start_zero_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    $fell(drv_reg) |-> cnt_reg == '0)
    else $error("off timer not restarted at turn-off");

  start_quiet_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    state_reg == srgs_pkg::SRGS_SYNC |=> state_reg != srgs_pkg::SRGS_ON && !drv_reg)
    else $error("drive left sync wait early");

  // counting in sync starts at once when sense already sits above re-arm
  wake_count_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN || lld_sync_reg)
    state_reg == srgs_pkg::SRGS_SYNC && sync_reg.above_rearm && cnt_reg + ONE < toff_lim
    |=> cnt_reg == $past(cnt_reg) + ONE)
    else $error("start-up timer not running");

  // disable level passes through both flops before use
  lld_sync_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    lld_sync_reg == $past(lld_meta_reg))
    else $error("disable synchroniser skipped");

  // second flop only ever copies the first one
  cmp_sync_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    sync_reg == $past(meta_reg))
    else $error("comparator synchroniser skipped");
endmodule

// File: verif/srgs_fet.sv
`timescale 1ns/1ns
module srgs_fet (
  // sense phase commanded by the bench
  input  wire logic           i_conduct,
  input  wire logic           i_ring,
  // comparator decisions seen at the drain
  output srgs_pkg::srgs_cmp_t o_cmp
);
  // conduction drags the drain below every level at once
  assign o_cmp.below_on    = i_conduct;
  assign o_cmp.above_off   = !i_conduct;
  // ringing dips under the re-arm level only
  assign o_cmp.above_rearm = !i_conduct && !i_ring;
endmodule

// File: verif/tb.sv
`timescale 1ns/1ns
module tb;
  localparam int TON  = 4;
  localparam int TOFF = 6;
  logic                clk;
  logic                rstn;
  logic                conduct;
  logic                ring;
  logic                light_load_input;
  logic                drv;
  logic [15:0]         ton_cfg;
  logic [15:0]         toff_cfg;
  srgs_pkg::srgs_cmp_t cmp;
  int                  mismatches;
  int                  checks_done;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t drive %b", $time, a); end end

  srgs_fet i_fet (.i_conduct(conduct), .i_ring(ring), .o_cmp(cmp));
  srgs_seq i_dut (
    .I_CLK                (clk),
    .I_RESETN             (rstn),
    .I_TURN_ON_THRESHOLD  (cmp.below_on),
    .I_TURN_OFF_THRESHOLD (cmp.above_off),
    .I_REARM_THRESHOLD    (cmp.above_rearm),
    .I_LIGHT_LOAD_INPUT   (light_load_input),
    .I_TON_CYC            (ton_cfg),
    .I_TOFF_CYC           (toff_cfg),
    .O_GATE_DRIVE_OUTPUT  (drv)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // inputs move 10 ns after each rising edge
  task cyc(int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task hold(logic v, int n);
    repeat (n) begin
      cyc(1);
      `CHK(drv, v)
    end
  endtask
  task reach(logic v, int n);
    int k;
    k = 0;
    while (drv !== v && k < n) begin
      cyc(1);
      k++;
    end
    `CHK(drv, v)
  endtask
  task arm_on;
    conduct = 1'b0;
    ring    = 1'b0;
    cyc(TOFF + 4);
    conduct = 1'b1;
    reach(1'b1, 6);
  endtask

  // start-up: ringing keeps cutting the off window short
  task t_start;
    conduct = 1'b0;
    repeat (4) begin
      ring = 1'b0;
      cyc(TOFF - 3);
      ring = 1'b1;
      cyc(1);
    end
    conduct = 1'b1;
    hold(1'b0, 10);
  endtask
  // turn-off during the on window waits for the window
  task t_blank;
    arm_on();
    conduct = 1'b0;
    hold(1'b1, TON - 1);
    reach(1'b0, 6);
  endtask
  // turn-on before the off window completes is refused
  task t_early;
    cyc(TOFF - 3);
    conduct = 1'b1;
    hold(1'b0, 10);
    arm_on();
    conduct = 1'b0;
    reach(1'b0, TON + 6);
  endtask
  // wake from disable needs a fresh clean window
  task t_wake;
    light_load_input = 1'b1;
    hold(1'b0, 4);
    conduct = 1'b0;
    cyc(TOFF + 4);
    light_load_input     = 1'b0;
    conduct = 1'b1;
    hold(1'b0, 8);
    arm_on();
  endtask
  // zero settings fall back to floors of 1 and 3 cycles
  task t_floor;
    ton_cfg  = 16'h0000;
    toff_cfg = 16'h0000;
    conduct  = 1'b0;
    repeat (4) begin
      ring = 1'b0;
      cyc(2);
      ring = 1'b1;
      cyc(1);
    end
    conduct = 1'b1;
    hold(1'b0, 6);
    arm_on();
    conduct = 1'b0;
    hold(1'b1, 2);
    hold(1'b0, 1);
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    test_done();
  end

  initial begin
    mismatches  = 0;
    checks_done = 0;
    rstn        = 1'b0;
    conduct     = 1'b1;
    ring        = 1'b0;
    light_load_input         = 1'b0;
    ton_cfg     = 16'h0004;
    toff_cfg    = 16'h0006;
    cyc(16);
    rstn = 1'b1;
    t_start();
    t_blank();
    t_early();
    t_wake();
    t_floor();
    test_done();
  end
endmodule
